// [hdl/teri_pkg.sv]
// Purpose: Shared constants for the translation buffer unit error record.
// Assumes: 32-bit register words, byte addresses on a 16-bit bus.
// Notes: Offsets other than the status record are local choices.
package teri_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_ERR_CTRL = 16'h8E88;
  localparam logic [15:0] OFS_ERR_STATUS = 16'h8E90;
  localparam logic [15:0] OFS_ERR_INJECT = 16'h8E98;
  localparam logic [15:0] OFS_SEC_CTRL = 16'h8EA0;
  localparam logic [15:0] OFS_EVT_STATUS = 16'h8EA4;
  localparam logic [15:0] OFS_EVT_CLEAR = 16'h8EA8;
  localparam logic [15:0] OFS_EVT_ENABLE = 16'h8EAC;
  // Record status fields
  localparam int POS_VALID = 30;
  localparam int POS_OVERFLOW = 27;
  localparam int POS_CE_LO = 24;
  localparam int POS_CE_HI = 25;
  localparam int POS_ERROR_SYNDROME_CODE_LO = 0;
  localparam int POS_ERROR_SYNDROME_CODE_HI = 7;
  // Control fields
  localparam int POS_IRQ_EN = 3;
  localparam int POS_NS_ACCESS = 0;
  localparam int POS_INJ_TAG = 1;
  localparam int POS_INJ_DATA = 0;
  // Event status bits
  localparam int EVT_W = 3;
  localparam int EVT_TAG = 0;
  localparam int EVT_DATA = 1;
  localparam int EVT_OVF = 2;
  // Values
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_CORRECTED = 2'h2;
  localparam logic [1:0] CE_CLEAR_KEY = 2'h3;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_TAG = 8'h07;
  localparam logic [7:0] CODE_DATA = 8'h08;
  localparam logic [31:0] RST_ERR_CTRL = 32'h0000_0008;
  localparam logic [31:0] RST_ERR_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_ERR_INJECT = 32'h0000_0000;
  localparam logic [31:0] RST_SEC_CTRL = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
endpackage

// [hdl/teri_fault_if.sv]
// Purpose: Carries injection controls and parity fault reports.
// Assumes: One clock domain shared by both ends.
// Notes: faultValid is a one-cycle pulse.
interface teri_fault_if;
  logic injTag;
  logic injData;
  logic faultValid;
  logic [7:0] faultCode;
  logic faultInjected;
  modport ctrl (
    output injTag,
    output injData,
    input faultValid,
    input faultCode,
    input faultInjected
  );
  modport chk (
    input injTag,
    input injData,
    output faultValid,
    output faultCode,
    output faultInjected
  );
endinterface

// [hdl/teri_tlb_parity.sv]
// Purpose: Parity bits of the main TLB entries, with fault injection.
// Assumes: Tag and data arrays themselves live outside this block.
// Notes: A lookup result appears one cycle after the lookup strobe.
module teri_tlb_parity
  import teri_pkg::*;
#(
  parameter int TAG_W = 32,
  parameter int DATA_W = 64,
  parameter int ENTRIES = 16,
  parameter int IDX_W = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tlbWrValid,
  input wire logic [IDX_W-1:0] tlbWrIndex,
  input wire logic [TAG_W-1:0] tlbWrTag,
  input wire logic [DATA_W-1:0] tlbWrData,
  input wire logic tlbRdValid,
  input wire logic [IDX_W-1:0] tlbRdIndex,
  input wire logic [TAG_W-1:0] tlbRdTag,
  input wire logic [DATA_W-1:0] tlbRdData,
  teri_fault_if.chk flt
);
  // Per entry: tag parity, data parity, written under injection
  typedef struct packed {
    logic [ENTRIES-1:0][2:0] par;
    logic fv;
    logic [7:0] code;
    logic inj;
  } teriPar_s;

  teriPar_s st_ff;
  teriPar_s nxt_st;
  logic tagBad;
  logic dataBad;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.fv = 1'b0;
    nxt_st.inj = 1'b0;
    tagBad = (^tlbRdTag) != st_ff.par[tlbRdIndex][2];
    dataBad = (^tlbRdData) != st_ff.par[tlbRdIndex][1];
    if (tlbWrValid)
    begin
      nxt_st.par[tlbWrIndex] = {(^tlbWrTag) ^ flt.injTag,
                                (^tlbWrData) ^ flt.injData,
                                flt.injTag | flt.injData};
    end
    if (tlbRdValid && (tagBad || dataBad))
    begin
      nxt_st.fv = 1'b1;
      // Tag fault hides a data fault on the same entry
      nxt_st.code = tagBad ? CODE_TAG : CODE_DATA;
      nxt_st.inj = st_ff.par[tlbRdIndex][0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign flt.faultValid = st_ff.fv;
  assign flt.faultCode = st_ff.code;
  assign flt.faultInjected = st_ff.inj;
endmodule

// [hdl/teri_top.sv]
// Purpose: Error record, injection and interrupt registers of one
//   translation buffer unit.
// Assumes: Plain register port, read data one cycle after the strobe.
// Notes: regNonsecure qualifies each access with its security state.
//
// Decided for this implementation: the address-and-strobe port.
module teri_top
  import teri_pkg::*;
#(
  parameter int TAG_W = 32,
  parameter int DATA_W = 64,
  parameter int ENTRIES = 16,
  parameter int IDX_W = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic regNonsecure,
  output logic [31:0] regRdata,
  input wire logic tlbWrValid,
  input wire logic [IDX_W-1:0] tlbWrIndex,
  input wire logic [TAG_W-1:0] tlbWrTag,
  input wire logic [DATA_W-1:0] tlbWrData,
  input wire logic tlbRdValid,
  input wire logic [IDX_W-1:0] tlbRdIndex,
  input wire logic [TAG_W-1:0] tlbRdTag,
  input wire logic [DATA_W-1:0] tlbRdData,
  output logic tlbFault,
  output logic mgmtFault,
  output logic errIrq
);
  typedef struct packed {
    logic irqEn;
    logic nsAccess;
    logic valid;
    logic overflow;
    logic [1:0] ce;
    logic [7:0] error_syndrome_code;
    logic injTag;
    logic injData;
    logic [EVT_W-1:0] evtStat;
    logic [EVT_W-1:0] evtEn;
    logic irq;
    logic tlbFault;
    logic mgmtFault;
    logic [31:0] rdata;
  } teri_state_s;

  teri_state_s st_ff;
  teri_state_s nxt_st;
  teri_fault_if flt ();

  logic accessOk;
  logic wrOk;
  logic rdOk;
  logic wrStatus;
  logic ceKey;
  logic ofClr;
  logic ceClr;
  logic vClr;
  logic [EVT_W-1:0] evtSet;
  logic [31:0] rdMux;

  teri_tlb_parity #(
    .TAG_W(TAG_W),
    .DATA_W(DATA_W),
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_parity (
    .clk(clk),
    .rstn(rstn),
    .tlbWrValid(tlbWrValid),
    .tlbWrIndex(tlbWrIndex),
    .tlbWrTag(tlbWrTag),
    .tlbWrData(tlbWrData),
    .tlbRdValid(tlbRdValid),
    .tlbRdIndex(tlbRdIndex),
    .tlbRdTag(tlbRdTag),
    .tlbRdData(tlbRdData),
    .flt(flt.chk)
  );

  assign flt.injTag = st_ff.injTag;
  assign flt.injData = st_ff.injData;

  // Secure accesses always pass; the grant bit itself is secure only
  assign accessOk = !regNonsecure || st_ff.nsAccess;
  assign wrOk = regWr && accessOk;
  assign rdOk = regRd && accessOk;

  // Clear qualifiers of the status record, judged on the old state
  assign wrStatus = wrOk && (regAddr == OFS_ERR_STATUS);
  assign ofClr = wrStatus && regWdata[POS_OVERFLOW];
  assign ceKey = regWdata[POS_CE_HI:POS_CE_LO] == CE_CLEAR_KEY;
  // Holding the field while overflow stands stops software losing a
  // second error it has not seen yet
  assign ceClr = wrStatus && ceKey && (!st_ff.overflow || ofClr);
  assign vClr = wrStatus && regWdata[POS_VALID]
                && ((st_ff.ce == CE_NONE) || ceClr);

  always_comb
  begin
    evtSet = '0;
    evtSet[EVT_TAG] = flt.faultValid && (flt.faultCode == CODE_TAG);
    evtSet[EVT_DATA] = flt.faultValid && (flt.faultCode == CODE_DATA);
    evtSet[EVT_OVF] = flt.faultValid
                      && ((st_ff.ce != CE_NONE) && !ceClr);
  end

  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (rdOk)
    begin
      case (regAddr)
        OFS_ERR_CTRL:
        begin
          rdMux[POS_IRQ_EN] = st_ff.irqEn;
        end
        OFS_ERR_STATUS:
        begin
          rdMux[POS_VALID] = st_ff.valid;
          rdMux[POS_OVERFLOW] = st_ff.overflow;
          rdMux[POS_CE_HI:POS_CE_LO] = st_ff.ce;
          rdMux[POS_ERROR_SYNDROME_CODE_HI:POS_ERROR_SYNDROME_CODE_LO] = st_ff.error_syndrome_code;
        end
        OFS_ERR_INJECT:
        begin
          rdMux[POS_INJ_TAG] = st_ff.injTag;
          rdMux[POS_INJ_DATA] = st_ff.injData;
        end
        OFS_SEC_CTRL:
        begin
          rdMux[POS_NS_ACCESS] = regNonsecure ? 1'b0 : st_ff.nsAccess;
        end
        OFS_EVT_STATUS:
        begin
          rdMux[EVT_W-1:0] = st_ff.evtStat;
        end
        OFS_EVT_ENABLE:
        begin
          rdMux[EVT_W-1:0] = st_ff.evtEn;
        end
        default:
        begin
          rdMux = 32'h0000_0000;
        end
      endcase
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = rdMux;
    nxt_st.tlbFault = flt.faultValid;
    nxt_st.mgmtFault = flt.faultValid && !flt.faultInjected;

    // Software writes to control registers
    if (wrOk)
    begin
      case (regAddr)
        OFS_ERR_CTRL:
        begin
          nxt_st.irqEn = regWdata[POS_IRQ_EN];
        end
        OFS_ERR_INJECT:
        begin
          nxt_st.injTag = regWdata[POS_INJ_TAG];
          nxt_st.injData = regWdata[POS_INJ_DATA];
        end
        OFS_SEC_CTRL:
        begin
          if (!regNonsecure)
            nxt_st.nsAccess = regWdata[POS_NS_ACCESS];
        end
        OFS_EVT_ENABLE:
        begin
          nxt_st.evtEn = regWdata[EVT_W-1:0];
        end
        OFS_EVT_CLEAR:
        begin
          nxt_st.evtStat = st_ff.evtStat & ~regWdata[EVT_W-1:0];
        end
        default:
        begin
          nxt_st.irqEn = st_ff.irqEn;
        end
      endcase
    end

    // Record clears first, so a same-cycle fault lands on top
    if (ofClr)
      nxt_st.overflow = 1'b0;
    if (ceClr)
    begin
      nxt_st.ce = CE_NONE;
      nxt_st.error_syndrome_code = CODE_NONE;
    end
    if (vClr)
      nxt_st.valid = 1'b0;

    // Parity fault report: valid and field set; overflow if a record stands, else the code
    if (flt.faultValid)
    begin
      nxt_st.valid = 1'b1;
      if (nxt_st.ce != CE_NONE)
        nxt_st.overflow = 1'b1;
      else
        nxt_st.error_syndrome_code = flt.faultCode;
      nxt_st.ce = CE_CORRECTED;
    end

    // Sticky events: a set beats a clear in the same cycle
    nxt_st.evtStat = nxt_st.evtStat | evtSet;
    nxt_st.irq = nxt_st.irqEn
                 && ((nxt_st.evtStat & nxt_st.evtEn) != '0);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff.irqEn <= RST_ERR_CTRL[POS_IRQ_EN];
      st_ff.nsAccess <= RST_SEC_CTRL[POS_NS_ACCESS];
      st_ff.valid <= RST_ERR_STATUS[POS_VALID];
      st_ff.overflow <= RST_ERR_STATUS[POS_OVERFLOW];
      st_ff.ce <= RST_ERR_STATUS[POS_CE_HI:POS_CE_LO];
      st_ff.error_syndrome_code <= RST_ERR_STATUS[POS_ERROR_SYNDROME_CODE_HI:POS_ERROR_SYNDROME_CODE_LO];
      st_ff.injTag <= RST_ERR_INJECT[POS_INJ_TAG];
      st_ff.injData <= RST_ERR_INJECT[POS_INJ_DATA];
      st_ff.evtStat <= RST_EVT;
      st_ff.evtEn <= RST_EVT;
      st_ff.irq <= 1'b0;
      st_ff.tlbFault <= 1'b0;
      st_ff.mgmtFault <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata = st_ff.rdata;
  assign tlbFault = st_ff.tlbFault;
  assign mgmtFault = st_ff.mgmtFault;
  assign errIrq = st_ff.irq;
endmodule

// [testbench/teri_top_properties.sv]
// Purpose: Port-level properties of the error record block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees only top-level ports; attached by bind below.
module teri_checker
  import teri_pkg::*;
(
  input logic clk,
  input logic rstn,
  input logic [ADDR_W-1:0] regAddr,
  input logic regRd,
  input logic regNonsecure,
  input logic [31:0] regRdata,
  input logic tlbRdValid,
  input logic tlbFault,
  input logic mgmtFault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Status read answered one cycle after its strobe
  sequence s_stRd;
    regRd && regAddr == OFS_ERR_STATUS ##1 1'b1;
  endsequence
  a_fault_pulse: assert property (tlbFault |=> !tlbFault)
    else $error("fault pulse longer than one cycle");
  a_fault_cause: assert property (tlbFault |-> $past(tlbRdValid, 2))
    else $error("fault without a lookup");
  a_mgmt_inject: assert property (mgmtFault |-> tlbFault)
    else $error("management report without fault");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  a_sec_raz: assert property (regRd && regNonsecure &&
    regAddr == OFS_SEC_CTRL |=> regRdata == 32'h0)
    else $error("security control visible to nonsecure");
  a_status_rsvd: assert property (s_stRd |->
    (regRdata & 32'hB4FF_FF00) == 32'h0)
    else $error("status reserved bits set");
  a_code_idle: assert property (s_stRd |->
    (regRdata[25:24] == CE_NONE) == (regRdata[7:0] == CODE_NONE))
    else $error("error code disagrees with field");
  a_valid_ce: assert property (s_stRd |->
    regRdata[25:24] == CE_NONE || regRdata[30])
    else $error("field set without valid flag");
  a_ovf_ce: assert property (s_stRd |->
    !regRdata[27] || regRdata[25:24] == CE_CORRECTED)
    else $error("overflow without corrected field");
endmodule

bind teri_top teri_checker i_teri_checker (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .regRd(regRd), .regNonsecure(regNonsecure),
  .regRdata(regRdata), .tlbRdValid(tlbRdValid), .tlbFault(tlbFault),
  .mgmtFault(mgmtFault));

// [testbench/tb.sv]
// Purpose: Self-checking bench for the error record block.
// Assumes: Register answers one cycle after the strobe.
// Notes: Table rows cover plain register access; faults follow.
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
  errCount++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  import teri_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TAG = 32'h1234_5678;
  localparam logic [63:0] DAT = 64'h0F0F_0000_A5A5_0001;
  typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] e;} teri_row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] regAddr = 16'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic regNonsecure = 1'b0;
  logic [31:0] regRdata;
  logic tlbWrValid = 1'b0;
  logic tlbRdValid = 1'b0;
  logic [3:0] tlbIdx = 4'h0;
  logic tlbFault;
  logic mgmtFault;
  logic errIrq;
  int errCount = 0;
  int samplesChecked = 0;
  teri_row_s rows[8] = '{
    '{OFS_ERR_INJECT, 32'hFFFF_FFFF, 32'h3},
    '{OFS_ERR_INJECT, 32'h0, 32'h0},
    '{OFS_ERR_CTRL, 32'hFFFF_FFFF, 32'h8},
    '{OFS_ERR_STATUS, 32'hFFFF_FFFF, 32'h0},
    '{OFS_SEC_CTRL, 32'h1, 32'h1},
    '{16'h8E00, 32'hFFFF_FFFF, 32'h0},
    '{OFS_EVT_STATUS, 32'hFFFF_FFFF, 32'h0},
    '{OFS_EVT_ENABLE, 32'h7, 32'h7}};
  teri_top i_teri_top (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regNonsecure(regNonsecure), .regRdata(regRdata),
    .tlbWrValid(tlbWrValid), .tlbWrIndex(tlbIdx), .tlbWrTag(TAG),
    .tlbWrData(DAT), .tlbRdValid(tlbRdValid), .tlbRdIndex(tlbIdx),
    .tlbRdTag(TAG), .tlbRdData(DAT), .tlbFault(tlbFault),
    .mgmtFault(mgmtFault), .errIrq(errIrq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("Checks %0d, errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask
  // Fault shows two edges after the lookup: parity stage, then record
  task automatic look(input logic [3:0] idx, input logic f, input logic m);
    @(posedge clk);
    tlbIdx <= idx;
    tlbRdValid <= 1'b1;
    @(posedge clk);
    tlbRdValid <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("tlbFault", f, tlbFault)
    `CHK("mgmtFault", m, mgmtFault)
  endtask
  // Entry written under the given injection, then looked up
  task automatic fault(input logic [1:0] inj, input logic [3:0] idx);
    wr(OFS_ERR_INJECT, {30'h0, inj});
    tlbIdx <= idx;
    @(posedge clk);
    tlbWrValid <= 1'b1;
    @(posedge clk);
    tlbWrValid <= 1'b0;
    look(idx, inj != 2'h0, 1'b0);
  endtask
  initial
  begin
    #200000;
    errCount++;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_ERR_CTRL, RST_ERR_CTRL);
    rd(OFS_ERR_STATUS, 32'h0);
    rd(OFS_ERR_INJECT, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    fault(2'h0, 4'h5);
    fault(2'h2, 4'h3);
    rd(OFS_ERR_STATUS, 32'h4200_0007);
    `CHK("errIrq", 1'b1, errIrq)
    fault(2'h1, 4'h6);
    rd(OFS_ERR_STATUS, 32'h4A00_0007);
    wr(OFS_ERR_STATUS, 32'h4000_0000);
    rd(OFS_ERR_STATUS, 32'h4A00_0007);
    wr(OFS_ERR_STATUS, 32'h0300_0000);
    rd(OFS_ERR_STATUS, 32'h4A00_0007);
    wr(OFS_ERR_STATUS, 32'h0800_0000);
    rd(OFS_ERR_STATUS, 32'h4200_0007);
    wr(OFS_ERR_STATUS, 32'h4300_0000);
    rd(OFS_ERR_STATUS, 32'h0);
    rd(OFS_EVT_STATUS, 32'h7);
    wr(OFS_EVT_CLEAR, 32'h7);
    rd(OFS_EVT_STATUS, 32'h0);
    `CHK("errIrq", 1'b0, errIrq)
    fault(2'h1, 4'h7);
    rd(OFS_ERR_STATUS, 32'h4200_0008);
    wr(OFS_ERR_STATUS, 32'h4300_0000);
    fault(2'h3, 4'h8);
    rd(OFS_ERR_STATUS, 32'h4200_0007);
    wr(OFS_ERR_CTRL, 32'h0);
    rd(OFS_ERR_CTRL, 32'h0);
    `CHK("errIrq", 1'b0, errIrq)
    wr(OFS_SEC_CTRL, 32'h0);
    regNonsecure <= 1'b1;
    wr(OFS_ERR_STATUS, 32'h4300_0000);
    rd(OFS_ERR_STATUS, 32'h0);
    rd(OFS_SEC_CTRL, 32'h0);
    rd(OFS_ERR_INJECT, 32'h0);
    regNonsecure <= 1'b0;
    rd(OFS_ERR_STATUS, 32'h4200_0007);
    // Second reset in mid-run must restore the status and control reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_ERR_STATUS, 32'h0);
    rd(OFS_ERR_CTRL, RST_ERR_CTRL);
    // Entry never written since reset has cleared parity: a real fault
    look(4'h0, 1'b1, 1'b1);
    rd(OFS_ERR_STATUS, 32'h4200_0007);
    `CHK("errIrq", 1'b0, errIrq)
    summarize;
  end
endmodule
